// *** aipc_pkg.sv ***
// shared constants for the interface and power configuration registers
package aipc_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_OUTPUT_INTERFACE_SELECT    = 12'h007;
  localparam logic [11:0] ADDR_POWER_DOWN_CONTROL         = 12'h008;
  localparam logic [11:0] ADDR_OUTPUT_DRIVER_DISABLE_LOW  = 12'h00A;
  localparam logic [11:0] ADDR_OUTPUT_DRIVER_DISABLE_MID  = 12'h00B;
  localparam logic [11:0] ADDR_OUTPUT_DRIVER_DISABLE_HIGH = 12'h00C;
  localparam logic [11:0] ADDR_SLEEP_MASK                 = 12'h00D;
  localparam logic [11:0] ADDR_FUSE_RELOAD                = 12'h013;

  localparam logic [7:0] RESET_VALUE = 8'h00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int VARIANT_LSB        = 5;
  localparam int OVERRIDE_BIT       = 3;
  localparam int MODE_LSB           = 0;
  localparam int CLKBUF_OFF_BIT     = 5;
  localparam int REFAMP_OFF_BIT     = 4;
  localparam int CHAN_A_OFF_BIT     = 2;
  localparam int CHAN_B_OFF_BIT     = 1;
  localparam int GLOBAL_SLEEP_BIT   = 0;
  localparam int KEEP_CLKBUF_BIT    = 3;
  localparam int KEEP_REFAMP_BIT    = 2;
  localparam int FUSE_RELOAD_BIT    = 0;
  localparam logic [7:0] WRITE_MASK_SELECT = 8'hEF;
  localparam logic [7:0] WRITE_MASK_POWER  = 8'h37;
  localparam logic [7:0] WRITE_MASK_SLEEP  = 8'h0E;

  // ----------------------------------------------------------------
  // codes
  // ----------------------------------------------------------------
  localparam logic [2:0] VARIANT_TWO_WIRE_18_14 = 3'h1;
  localparam logic [2:0] VARIANT_TWO_WIRE_16    = 3'h2;
  localparam logic [2:0] VARIANT_ONE_WIRE       = 3'h3;
  localparam logic [2:0] VARIANT_HALF_WIRE      = 3'h4;
  localparam logic [2:0] VARIANT_DDR            = 3'h5;
  localparam logic [2:0] MODE_DDR_CMOS          = 3'h1;
  localparam logic [2:0] MODE_TWO_WIRE          = 3'h3;
  localparam logic [2:0] MODE_ONE_WIRE          = 3'h4;
  localparam logic [2:0] MODE_HALF_WIRE         = 3'h5;

  typedef enum logic [2:0] {
    AIPC_IF_NONE,
    AIPC_IF_DDR,
    AIPC_IF_TWO_WIRE,
    AIPC_IF_ONE_WIRE,
    AIPC_IF_HALF_WIRE
  } aipc_if_t;

  typedef enum logic [2:0] {
    AIPC_MAP_NONE,
    AIPC_MAP_TWO_WIRE_18_14,
    AIPC_MAP_TWO_WIRE_16,
    AIPC_MAP_ONE_WIRE,
    AIPC_MAP_HALF_WIRE,
    AIPC_MAP_DDR
  } aipc_map_t;

endpackage

// *** aipc_regs.sv ***
// interface select, power-down and output driver disable registers
//
// What this block does
// - bit-map variant codes decode to five layouts
// - variant applies only on fuse reload command
// - fuse default active; variant reads zero initially
// - override bit gates the mode select field
// - mode select codes decode to four interfaces
// - fuse mode active; mode reads zero initially
// - bit five powers down sample clock buffer
// - bit four powers down reference gain amp
// - bit two powers down channel a
// - bit one powers down channel b
// - bit zero enters masked global sleep
// - each disable bit powers down one driver
// - sleep spares clock buffer when mask set
`timescale 1ns/1ps

module aipc_regs
  import aipc_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  input  wire logic        i_wr_en,
  input  wire logic        i_rd_en,
  input  wire logic [11:0] i_addr,
  input  wire logic [7:0]  i_wr_data,
  input  wire logic [2:0]  i_fuse_mode,
  input  wire logic [2:0]  i_fuse_variant,
  output logic      [7:0]  o_rd_data,
  output logic             o_rd_valid,
  output logic             o_fuse_reload,
  output aipc_if_t         o_active_mode,
  output aipc_map_t        o_active_variant,
  output logic             o_sample_clock_buffer_off,
  output logic             o_reference_gain_amp_off,
  output logic             o_channel_a_off,
  output logic             o_channel_b_off,
  output logic      [23:0] o_output_driver_disable
);

  // ----------------------------------------------------------------
  // decoders
  // ----------------------------------------------------------------
  // unused codes fall to the none value and select nothing
  function automatic aipc_if_t decode_mode(input logic [2:0] code);
    case (code)
      MODE_DDR_CMOS:  decode_mode = AIPC_IF_DDR;
      MODE_TWO_WIRE:  decode_mode = AIPC_IF_TWO_WIRE;
      MODE_ONE_WIRE:  decode_mode = AIPC_IF_ONE_WIRE;
      MODE_HALF_WIRE: decode_mode = AIPC_IF_HALF_WIRE;
      default:        decode_mode = AIPC_IF_NONE;
    endcase
  endfunction

  function automatic aipc_map_t decode_variant(input logic [2:0] code);
    case (code)
      VARIANT_TWO_WIRE_18_14: decode_variant = AIPC_MAP_TWO_WIRE_18_14;
      VARIANT_TWO_WIRE_16:    decode_variant = AIPC_MAP_TWO_WIRE_16;
      VARIANT_ONE_WIRE:       decode_variant = AIPC_MAP_ONE_WIRE;
      VARIANT_HALF_WIRE:      decode_variant = AIPC_MAP_HALF_WIRE;
      VARIANT_DDR:            decode_variant = AIPC_MAP_DDR;
      default:                decode_variant = AIPC_MAP_NONE;
    endcase
  endfunction

  typedef enum logic [2:0] {
    AIPC_REG_NONE,
    AIPC_REG_SELECT,
    AIPC_REG_POWER,
    AIPC_REG_DRIVER_LOW,
    AIPC_REG_DRIVER_MID,
    AIPC_REG_DRIVER_HIGH,
    AIPC_REG_SLEEP_MASK,
    AIPC_REG_RELOAD
  } aipc_reg_t;

  // write and read share one address decode so they cannot drift apart
  function automatic aipc_reg_t decode_addr(input logic [11:0] addr);
    case (addr)
      ADDR_OUTPUT_INTERFACE_SELECT:    decode_addr = AIPC_REG_SELECT;
      ADDR_POWER_DOWN_CONTROL:         decode_addr = AIPC_REG_POWER;
      ADDR_OUTPUT_DRIVER_DISABLE_LOW:  decode_addr = AIPC_REG_DRIVER_LOW;
      ADDR_OUTPUT_DRIVER_DISABLE_MID:  decode_addr = AIPC_REG_DRIVER_MID;
      ADDR_OUTPUT_DRIVER_DISABLE_HIGH: decode_addr = AIPC_REG_DRIVER_HIGH;
      ADDR_SLEEP_MASK:                 decode_addr = AIPC_REG_SLEEP_MASK;
      ADDR_FUSE_RELOAD:                decode_addr = AIPC_REG_RELOAD;
      default:                         decode_addr = AIPC_REG_NONE;
    endcase
  endfunction

  // direct request, or swept up by global sleep unless its keep bit is set
  function automatic logic gated_off(input logic own, input logic sleep, input logic keep);
    gated_off = own | (sleep & ~keep);
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  // all state in one struct: one process fills it, one registers it
  typedef struct packed {
    logic [7:0]  output_interface_select;
    logic [7:0]  power_down_control;
    logic [7:0]  output_driver_disable_low;
    logic [7:0]  output_driver_disable_mid;
    logic [7:0]  output_driver_disable_high;
    logic [7:0]  sleep_mask;
    logic        fuse_loaded;
    logic [2:0]  fuse_mode;
    logic [2:0]  fuse_variant;
    logic [2:0]  mode_sync1;
    logic [2:0]  mode_sync2;
    logic [2:0]  variant_sync1;
    logic [2:0]  variant_sync2;
    logic        sync_ready1;
    logic        sync_ready2;
    logic [7:0]  rd_data;
    logic        rd_valid;
    logic        fuse_reload;
    aipc_if_t    active_mode;
    aipc_map_t   active_variant;
    logic        clkbuf_off;
    logic        refamp_off;
    logic        chan_a_off;
    logic        chan_b_off;
    logic [23:0] driver_disable;
  } aipc_state_t;

  aipc_state_t state;
  aipc_state_t next_state;

  localparam aipc_state_t STATE_RESET = '{
    output_interface_select:    RESET_VALUE,
    power_down_control:         RESET_VALUE,
    output_driver_disable_low:  RESET_VALUE,
    output_driver_disable_mid:  RESET_VALUE,
    output_driver_disable_high: RESET_VALUE,
    sleep_mask:                 RESET_VALUE,
    fuse_loaded:                1'b0,
    fuse_mode:                  3'h0,
    fuse_variant:               3'h0,
    mode_sync1:                 3'h0,
    mode_sync2:                 3'h0,
    variant_sync1:              3'h0,
    variant_sync2:              3'h0,
    sync_ready1:                1'b0,
    sync_ready2:                1'b0,
    rd_data:                    RESET_VALUE,
    rd_valid:                   1'b0,
    fuse_reload:                1'b0,
    active_mode:                AIPC_IF_NONE,
    active_variant:             AIPC_MAP_NONE,
    clkbuf_off:                 1'b0,
    refamp_off:                 1'b0,
    chan_a_off:                 1'b0,
    chan_b_off:                 1'b0,
    driver_disable:             24'h000000
  };

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic       sleep;
    logic [2:0] mode_code;
    logic       reload;
    aipc_reg_t  sel;
    next_state = state;
    sleep = 1'b0;
    mode_code = 3'h0;
    reload = 1'b0;
    sel = decode_addr(i_addr);

    // fuse straps are pins: two flops before use
    next_state.mode_sync1    = i_fuse_mode;
    next_state.mode_sync2    = state.mode_sync1;
    next_state.variant_sync1 = i_fuse_variant;
    next_state.variant_sync2 = state.variant_sync1;

    // fuse defaults caught once, after release and synchronisation;
    // the ready pair marks when the second stage holds the strap value
    next_state.sync_ready1 = 1'b1;
    next_state.sync_ready2 = state.sync_ready1;
    if (!state.fuse_loaded && state.sync_ready2)
    begin
      next_state.fuse_loaded    = 1'b1;
      next_state.fuse_mode      = state.mode_sync2;
      next_state.fuse_variant   = state.variant_sync2;
      next_state.active_variant = decode_variant(state.variant_sync2);
    end

    if (i_wr_en)
    begin
      case (sel)
        AIPC_REG_SELECT:
          next_state.output_interface_select = i_wr_data & WRITE_MASK_SELECT;
        AIPC_REG_POWER:
          next_state.power_down_control = i_wr_data & WRITE_MASK_POWER;
        AIPC_REG_DRIVER_LOW:
          next_state.output_driver_disable_low = i_wr_data;
        AIPC_REG_DRIVER_MID:
          next_state.output_driver_disable_mid = i_wr_data;
        AIPC_REG_DRIVER_HIGH:
          next_state.output_driver_disable_high = i_wr_data;
        // bit 1 of the mask is kept for readback only; it steers nothing here
        AIPC_REG_SLEEP_MASK:
          next_state.sleep_mask = i_wr_data & WRITE_MASK_SLEEP;
        AIPC_REG_RELOAD:
          reload = i_wr_data[FUSE_RELOAD_BIT];
        default: ;
      endcase
    end

    // reload discards earlier writes except the select register
    // a write to any register but select landing in the clear cycle is lost with the rest
    next_state.fuse_reload = reload;
    if (state.fuse_reload)
    begin
      next_state.power_down_control         = RESET_VALUE;
      next_state.output_driver_disable_low  = RESET_VALUE;
      next_state.output_driver_disable_mid  = RESET_VALUE;
      next_state.output_driver_disable_high = RESET_VALUE;
      next_state.sleep_mask                 = RESET_VALUE;
      if (state.output_interface_select[VARIANT_LSB +: 3] != 3'h0)
        next_state.active_variant =
          decode_variant(state.output_interface_select[VARIANT_LSB +: 3]);
      else
        next_state.active_variant = decode_variant(state.fuse_variant);
    end

    // mode follows override bit live; fuse default otherwise
    if (state.output_interface_select[OVERRIDE_BIT])
      mode_code = state.output_interface_select[MODE_LSB +: 3];
    else
      mode_code = state.fuse_loaded ? state.fuse_mode : state.mode_sync2;
    next_state.active_mode = decode_mode(mode_code);

    sleep = state.power_down_control[GLOBAL_SLEEP_BIT];
    next_state.clkbuf_off = gated_off(state.power_down_control[CLKBUF_OFF_BIT], sleep,
                                      state.sleep_mask[KEEP_CLKBUF_BIT]);
    next_state.refamp_off = gated_off(state.power_down_control[REFAMP_OFF_BIT], sleep,
                                      state.sleep_mask[KEEP_REFAMP_BIT]);
    // the channels have no keep bit, so sleep always takes them down
    next_state.chan_a_off = gated_off(state.power_down_control[CHAN_A_OFF_BIT], sleep,
                                      1'b0);
    next_state.chan_b_off = gated_off(state.power_down_control[CHAN_B_OFF_BIT], sleep,
                                      1'b0);
    next_state.driver_disable = {state.output_driver_disable_high,
                                 state.output_driver_disable_mid,
                                 state.output_driver_disable_low};

    // read port; unmapped addresses read zero
    // a read beside a write to the same address returns the old value
    next_state.rd_valid = i_rd_en;
    next_state.rd_data  = RESET_VALUE;
    if (i_rd_en)
    begin
      case (sel)
        AIPC_REG_SELECT:      next_state.rd_data = state.output_interface_select;
        AIPC_REG_POWER:       next_state.rd_data = state.power_down_control;
        AIPC_REG_DRIVER_LOW:  next_state.rd_data = state.output_driver_disable_low;
        AIPC_REG_DRIVER_MID:  next_state.rd_data = state.output_driver_disable_mid;
        AIPC_REG_DRIVER_HIGH: next_state.rd_data = state.output_driver_disable_high;
        AIPC_REG_SLEEP_MASK:  next_state.rd_data = state.sleep_mask;
        // the reload command is write-only and reads zero like any hole
        default:              next_state.rd_data = RESET_VALUE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // async reset loads constants only; the straps are sampled afresh after it
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
      state <= STATE_RESET;
    else
      state <= next_state;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_rd_data                 = state.rd_data;
  assign o_rd_valid                = state.rd_valid;
  assign o_fuse_reload             = state.fuse_reload;
  assign o_active_mode             = state.active_mode;
  assign o_active_variant          = state.active_variant;
  assign o_sample_clock_buffer_off = state.clkbuf_off;
  assign o_reference_gain_amp_off  = state.refamp_off;
  assign o_channel_a_off           = state.chan_a_off;
  assign o_channel_b_off           = state.chan_b_off;
  assign o_output_driver_disable   = state.driver_disable;

endmodule

// *** aipc_regs_checker.sv ***
// port assertions for the interface and power configuration registers
`timescale 1ns/1ps

module aipc_regs_checker
  import aipc_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  input  wire logic        i_wr_en,
  input  wire logic        i_rd_en,
  input  wire logic [11:0] i_addr,
  input  wire logic [7:0]  i_wr_data,
  input  wire logic        o_rd_valid,
  input  wire logic        o_fuse_reload,
  input  aipc_if_t         o_active_mode,
  input  aipc_map_t        o_active_variant,
  input  wire logic        o_sample_clock_buffer_off,
  input  wire logic        o_reference_gain_amp_off,
  input  wire logic        o_channel_a_off,
  input  wire logic        o_channel_b_off,
  input  wire logic [23:0] o_output_driver_disable
);
  logic wr07;
  logic wr08;
  logic wr0a;
  logic wr13;
  assign wr07 = i_wr_en && i_addr == ADDR_OUTPUT_INTERFACE_SELECT;
  assign wr08 = i_wr_en && i_addr == ADDR_POWER_DOWN_CONTROL;
  assign wr0a = i_wr_en && i_addr == ADDR_OUTPUT_DRIVER_DISABLE_LOW;
  assign wr13 = i_wr_en && i_addr == ADDR_FUSE_RELOAD;

  // unused codes never reach this, antecedents filter them
  function automatic aipc_if_t dec_mode(input logic [2:0] c);
    case (c)
      MODE_DDR_CMOS: return AIPC_IF_DDR;
      MODE_TWO_WIRE: return AIPC_IF_TWO_WIRE;
      MODE_ONE_WIRE: return AIPC_IF_ONE_WIRE;
      default:       return AIPC_IF_HALF_WIRE;
    endcase
  endfunction

  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);

  a_read_answer_due: assert property (i_rd_en |=> o_rd_valid)
    else $error("read answer missing");
  a_read_no_extra: assert property (!i_rd_en |=> !o_rd_valid)
    else $error("read answer without request");
  a_reload_pulse_due: assert property (wr13 && i_wr_data[0] |=> o_fuse_reload)
    else $error("reload pulse missing");
  a_variant_needs_reload: assert property ($changed(o_active_variant)
    && $past(o_active_variant) != AIPC_MAP_NONE |-> $past(o_fuse_reload))
    else $error("variant changed without reload");
  a_mode_override_decode: assert property (wr07 && i_wr_data[3]
    && i_wr_data[2:0] inside {3'h1, 3'h3, 3'h4, 3'h5}
    |-> ##2 o_active_mode == dec_mode($past(i_wr_data[2:0], 2)))
    else $error("mode override not applied");
  a_power_bits_follow: assert property (wr08 && !i_wr_data[0] |-> ##2
    {o_sample_clock_buffer_off, o_reference_gain_amp_off, o_channel_a_off, o_channel_b_off}
    == $past({i_wr_data[5], i_wr_data[4], i_wr_data[2], i_wr_data[1]}, 2))
    else $error("power outputs differ from written bits");
  a_global_sleep_channels: assert property (wr08 && i_wr_data[0]
    |-> ##2 o_channel_a_off && o_channel_b_off)
    else $error("global sleep left a channel on");
  a_driver_low_byte: assert property (wr0a
    |-> ##2 o_output_driver_disable[7:0] == $past(i_wr_data, 2))
    else $error("driver disable low byte wrong");

  c_reload: cover property (o_fuse_reload);
  c_sleep: cover property (wr08 && i_wr_data[0]);
  c_read: cover property (o_rd_valid);
endmodule

bind aipc_regs aipc_regs_checker i_aipc_regs_checker (.i_clk(i_clk), .i_reset(i_reset),
  .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .i_addr(i_addr), .i_wr_data(i_wr_data),
  .o_rd_valid(o_rd_valid), .o_fuse_reload(o_fuse_reload), .o_active_mode(o_active_mode),
  .o_active_variant(o_active_variant), .o_channel_a_off(o_channel_a_off),
  .o_sample_clock_buffer_off(o_sample_clock_buffer_off), .o_channel_b_off(o_channel_b_off),
  .o_reference_gain_amp_off(o_reference_gain_amp_off),
  .o_output_driver_disable(o_output_driver_disable));

// *** aipc_host.sv ***
// host model driving the register strobes of the serial port front end
`timescale 1ns/1ps

module aipc_host
(
  input  wire logic        i_clk,
  input  wire logic        i_rd_valid,
  input  wire logic [7:0]  i_rd_data,
  output logic             o_wr_en,
  output logic             o_rd_en,
  output logic      [11:0] o_addr,
  output logic      [7:0]  o_wr_data
);
  initial
  begin
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_addr = 12'h000;
    o_wr_data = 8'h00;
  end

  // idle bus shows inverted junk, so a stale value cannot pass
  task automatic release_bus();
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_addr = ~o_addr;
    o_wr_data = ~o_wr_data;
  endtask

  // returns once the write has reached the outputs
  task automatic write(input logic [11:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_addr = a;
    o_wr_data = d;
    o_wr_en = 1'b1;
    @(negedge i_clk);
    release_bus();
    repeat (2) @(negedge i_clk);
  endtask

  task automatic read(input logic [11:0] a, output logic [7:0] d);
    int n;
    @(negedge i_clk);
    o_addr = a;
    o_rd_en = 1'b1;
    @(negedge i_clk);
    release_bus();
    n = 0;
    while (i_rd_valid !== 1'b1 && n < 4)
    begin
      @(negedge i_clk);
      n++;
    end
    d = (i_rd_valid === 1'b1) ? i_rd_data : 8'hXX;
  endtask
endmodule

// *** aipc_regs_tb.sv ***
// self-checking bench for the interface and power configuration registers
`timescale 1ns/1ps

module aipc_regs_tb
  import aipc_pkg::*;
;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        wr_en;
  logic        rd_en;
  logic        rd_valid;
  logic        fuse_reload;
  logic [11:0] addr;
  logic [7:0]  wr_data;
  logic [7:0]  rd_data;
  logic [2:0]  fuse_mode = MODE_TWO_WIRE;
  logic [2:0]  fuse_variant = VARIANT_DDR;
  aipc_if_t    mode;
  aipc_map_t   variant;
  logic [3:0]  pwr;
  logic [23:0] drv;
  int          err_count = 0;
  int          n_compared = 0;
  int          cycles = 0;
  int          n_reload = 0;

  always #12.5 clk = ~clk;

  // counts reload pulses, so one stuck high shows up as extra counts
  always @(posedge clk)
    if (fuse_reload === 1'b1)
      n_reload++;

  aipc_host i_aipc_host (.i_clk(clk), .i_rd_valid(rd_valid), .i_rd_data(rd_data),
    .o_wr_en(wr_en), .o_rd_en(rd_en), .o_addr(addr), .o_wr_data(wr_data));

  aipc_regs i_aipc_regs (.i_clk(clk), .i_reset(reset), .i_wr_en(wr_en), .i_rd_en(rd_en),
    .i_addr(addr), .i_wr_data(wr_data), .i_fuse_mode(fuse_mode),
    .i_fuse_variant(fuse_variant), .o_rd_data(rd_data), .o_rd_valid(rd_valid),
    .o_fuse_reload(fuse_reload), .o_active_mode(mode), .o_active_variant(variant),
    .o_sample_clock_buffer_off(pwr[3]), .o_reference_gain_amp_off(pwr[2]),
    .o_channel_a_off(pwr[1]), .o_channel_b_off(pwr[0]), .o_output_driver_disable(drv));

  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rd_chk(input string what, input logic [11:0] a, input logic [7:0] exp);
    logic [7:0] d;
    i_aipc_host.read(a, d);
    n_compared++;
    if (d !== exp)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, d);
    end
  endtask

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_after_reset();
    rd_chk("select", ADDR_OUTPUT_INTERFACE_SELECT, 8'h00);
    rd_chk("unmapped", 12'h009, 8'h00);
    chk("fuse mode", 24'(AIPC_IF_TWO_WIRE), 24'(mode));
    chk("fuse variant", 24'(AIPC_MAP_DDR), 24'(variant));
    chk("drivers", 24'h000000, drv);
    $display("t_after_reset done");
  endtask

  // select then reload first, since the reload clears earlier writes
  task automatic t_variant();
    logic [2:0] c [5] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5};
    aipc_map_t  w [5] = '{AIPC_MAP_TWO_WIRE_18_14, AIPC_MAP_TWO_WIRE_16,
                          AIPC_MAP_ONE_WIRE, AIPC_MAP_HALF_WIRE, AIPC_MAP_DDR};
    aipc_map_t  prev = AIPC_MAP_DDR;
    for (int i = 0; i < 5; i++)
    begin
      i_aipc_host.write(ADDR_OUTPUT_INTERFACE_SELECT, {c[i], 5'h00});
      chk("variant before reload", 24'(prev), 24'(variant));
      rd_chk("variant readback", ADDR_OUTPUT_INTERFACE_SELECT, {c[i], 5'h00});
      i_aipc_host.write(ADDR_FUSE_RELOAD, 8'h01);
      chk("variant after reload", 24'(w[i]), 24'(variant));
      chk("reload pulses", 24'(i + 1), 24'(n_reload));
      prev = w[i];
    end
    $display("t_variant done");
  endtask

  task automatic t_mode();
    logic [2:0] c [4] = '{3'h1, 3'h3, 3'h4, 3'h5};
    aipc_if_t   w [4] = '{AIPC_IF_DDR, AIPC_IF_TWO_WIRE, AIPC_IF_ONE_WIRE, AIPC_IF_HALF_WIRE};
    for (int i = 0; i < 4; i++)
    begin
      i_aipc_host.write(ADDR_OUTPUT_INTERFACE_SELECT, {5'h01, c[i]});
      chk("override mode", 24'(w[i]), 24'(mode));
    end
    i_aipc_host.write(ADDR_OUTPUT_INTERFACE_SELECT, 8'h01);
    chk("override off", 24'(AIPC_IF_TWO_WIRE), 24'(mode));
    rd_chk("mode readback", ADDR_OUTPUT_INTERFACE_SELECT, 8'h01);
    $display("t_mode done");
  endtask

  task automatic t_power();
    int b [4] = '{5, 4, 2, 1};
    for (int i = 0; i < 4; i++)
    begin
      i_aipc_host.write(ADDR_POWER_DOWN_CONTROL, 8'(1 << b[i]));
      chk("power bit", 24'({b[i] == 5, b[i] == 4, b[i] == 2, b[i] == 1}), 24'(pwr));
      rd_chk("power readback", ADDR_POWER_DOWN_CONTROL, 8'(1 << b[i]));
    end
    $display("t_power done");
  endtask

  task automatic t_sleep();
    i_aipc_host.write(ADDR_SLEEP_MASK, 8'h08);
    i_aipc_host.write(ADDR_POWER_DOWN_CONTROL, 8'h01);
    chk("sleep kept clock", 24'h000007, 24'(pwr));
    i_aipc_host.write(ADDR_SLEEP_MASK, 8'h00);
    chk("sleep all off", 24'h00000F, 24'(pwr));
    i_aipc_host.write(ADDR_POWER_DOWN_CONTROL, 8'h00);
    chk("sleep left", 24'h000000, 24'(pwr));
    $display("t_sleep done");
  endtask

  task automatic t_drivers();
    i_aipc_host.write(ADDR_OUTPUT_DRIVER_DISABLE_LOW, 8'h7F);
    i_aipc_host.write(ADDR_OUTPUT_DRIVER_DISABLE_MID, 8'hEE);
    i_aipc_host.write(ADDR_OUTPUT_DRIVER_DISABLE_HIGH, 8'hFC);
    chk("drivers", 24'hFCEE7F, drv);
    rd_chk("driver mid", ADDR_OUTPUT_DRIVER_DISABLE_MID, 8'hEE);
    i_aipc_host.write(ADDR_OUTPUT_DRIVER_DISABLE_LOW, 8'h00);
    chk("drivers low clear", 24'hFCEE00, drv);
    i_aipc_host.write(ADDR_FUSE_RELOAD, 8'h01);
    chk("drivers after reload", 24'h000000, drv);
    chk("variant fuse reload", 24'(AIPC_MAP_DDR), 24'(variant));
    $display("t_drivers done");
  endtask

  // about 160 cycles are needed
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      err_count++;
      $display("BAD timeout expected done seen hang");
      complete_run();
    end
  end

  initial
  begin
    repeat (8) @(negedge clk);
    reset = 1'b0;
    repeat (6) @(negedge clk);
    t_after_reset();
    t_variant();
    t_mode();
    t_power();
    t_sleep();
    t_drivers();
    complete_run();
  end
endmodule
